// ---- bst_pkg.sv ----
package bst_pkg;

    // tap controller states, sixteen of them
    typedef enum logic [3:0] {
        ST_RESET,
        ST_IDLE,
        ST_SEL_DR,
        ST_CAP_DR,
        ST_SHIFT_DR,
        ST_EXIT1_DR,
        ST_PAUSE_DR,
        ST_EXIT2_DR,
        ST_UPD_DR,
        ST_SEL_IR,
        ST_CAP_IR,
        ST_SHIFT_IR,
        ST_EXIT1_IR,
        ST_PAUSE_IR,
        ST_EXIT2_IR,
        ST_UPD_IR
    } bst_state_e;

    // scan lengths
    localparam int IR_W = 3;
    localparam int ID_W = 32;
    localparam int BSR_W = 109;
    localparam int TRI_CELL = 108;
    localparam int RST_CNT = 5;

    // instruction codes
    localparam logic [2:0] IR_EXTEST = 3'h0;
    localparam logic [2:0] IR_IDCODE = 3'h1;
    localparam logic [2:0] IR_SAMPLEZ = 3'h2;
    localparam logic [2:0] IR_PRELOAD = 3'h4;
    localparam logic [2:0] IR_BYPASS = 3'h7;
    localparam logic [2:0] IR_CAPTURE = 3'h1;

    // data register selection
    localparam logic [1:0] SEL_BSR = 2'h0;
    localparam logic [1:0] SEL_ID = 2'h1;
    localparam logic [1:0] SEL_BYP = 2'h2;

    // register map, byte addresses
    localparam logic [3:0] OFF_CTRL = 4'h0;
    localparam logic [3:0] OFF_STATUS = 4'h4;
    localparam logic [3:0] OFF_IDCODE = 4'h8;
    localparam int CTRL_RST_BIT = 0;
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_IR_LSB = 4;
    localparam int STAT_OE_BIT = 7;
    localparam int STAT_DRV_BIT = 8;

    // reset values
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;
    localparam logic PIN_PULL = 1'b1;

endpackage : bst_pkg

// ---- bst_tap.sv ----
`timescale 1ns/1ps
// Summary of operation
// - sample on clock rise, drive on fall
// - mode-select reads high when left open; here only its synchroniser is preset high at power-up, the pin has no pull-up
// - instruction picks register in serial path
// - shift in at msb, out at lsb
// - data out enabled only while shifting
// - five high mode-select rises reach reset
// - test reset leaves memory undisturbed
// - power-up reset, data out high impedance
// - exactly one register between in and out
// - three-bit instruction register, loaded serially
// - reset loads identification instruction
// - capture-instruction loads 01 into low bits
// - one-bit bypass register
// - bypass register captures low
// - boundary register covers every pin cell
// - capture pin ring, then shift it
// - test and sample instructions capture ring
// - state machine follows boundary-scan standard
// - identification code captured and shifted out
// - sample-z floats output bus until update
// - cell 108 gates output drivers under extest, preset high
// - three reserved codes, treated as bypass
module bst_tap #(
    parameter logic [31:0] ID_CODE = 32'h1234_5679 // value is arbitrary
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe,
    input wire logic [bst_pkg::BSR_W-1:0] pin_ring,
    output logic [bst_pkg::BSR_W-1:0] bsr_drive,
    output logic extest_active,
    output logic q_drive_en,
    input wire logic [1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    import bst_pkg::*;

    typedef struct packed {
        logic tck_s1;
        logic tck_s2;
        logic tck_d;
        logic tms_s1;
        logic tms_s2;
        logic tdi_s1;
        logic tdi_s2;
        logic [BSR_W-1:0] ring_s1;
        logic [BSR_W-1:0] ring_s2;
        bst_state_e state;
        logic [IR_W-1:0] ir;
        logic [IR_W-1:0] ir_sh;
        logic byp;
        logic [ID_W-1:0] id_sh;
        logic [BSR_W-1:0] bsr_sh; // one cell per ring pin
        logic [BSR_W-1:0] bsr_up;
        logic tdo;
        logic tdo_oe;
        logic ack;
        logic soft_rst;
        logic [31:0] rdata;
        logic [2:0] tms_cnt;
    } bst_regs_s;

    bst_regs_s s_r;
    bst_regs_s s_nxt;

    logic tck_rise;
    logic tck_fall;
    logic [1:0] dr_sel;
    logic [3:0] byte_addr;

    // edges come from the settled copies only, never from the first stage
    assign tck_rise = s_r.tck_s2 & ~s_r.tck_d;
    assign tck_fall = ~s_r.tck_s2 & s_r.tck_d;
    assign byte_addr = {avs_address, 2'b00};

    // data register chosen by the active instruction
    always_comb begin
        case (s_r.ir)
            IR_EXTEST, IR_SAMPLEZ, IR_PRELOAD: begin
                dr_sel = SEL_BSR;
            end
            IR_IDCODE: dr_sel = SEL_ID;
            default: dr_sel = SEL_BYP; // reserved codes fall to bypass
        endcase
    end

    // next controller state, decided by mode-select at each rise
    function automatic bst_state_e tap_next(bst_state_e st, logic m);
        bst_state_e r;
        r = st;
        case (st)
            ST_RESET: r = m ? ST_RESET : ST_IDLE;
            ST_IDLE: r = m ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: r = m ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: r = m ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: r = m ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: r = m ? ST_UPD_DR : ST_PAUSE_DR;
            ST_PAUSE_DR: r = m ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: r = m ? ST_UPD_DR : ST_SHIFT_DR;
            ST_UPD_DR: r = m ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: r = m ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: r = m ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: r = m ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: r = m ? ST_UPD_IR : ST_PAUSE_IR;
            ST_PAUSE_IR: r = m ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: r = m ? ST_UPD_IR : ST_SHIFT_IR;
            ST_UPD_IR: r = m ? ST_SEL_DR : ST_IDLE;
            default: r = ST_RESET;
        endcase
        return r;
    endfunction : tap_next

    // whole next state of the block
    always_comb begin
        s_nxt = s_r;
        // two-stage synchronisers on the test clock, mode-select, data-in and pin ring; bus inputs and reset_n are used directly
        s_nxt.tck_s1 = tck;
        s_nxt.tck_s2 = s_r.tck_s1;
        s_nxt.tck_d = s_r.tck_s2;
        s_nxt.tms_s1 = tms;
        s_nxt.tms_s2 = s_r.tms_s1;
        s_nxt.tdi_s1 = tdi;
        s_nxt.tdi_s2 = s_r.tdi_s1;
        // ring sampled asynchronously: values in transition are not reliable
        s_nxt.ring_s1 = pin_ring;
        s_nxt.ring_s2 = s_r.ring_s1;
        s_nxt.ack = 1'b0;
        s_nxt.soft_rst = 1'b0;

        // bus: first cycle latches read data, second cycle completes
        if ((avs_read || avs_write) && !s_r.ack) begin
            s_nxt.ack = 1'b1;
            s_nxt.rdata = RDATA_RST;
            if (avs_read) begin
                case (byte_addr)
                    OFF_STATUS: begin
                        s_nxt.rdata[STAT_STATE_LSB +: 4] = s_r.state;
                        s_nxt.rdata[STAT_IR_LSB +: IR_W] = s_r.ir;
                        s_nxt.rdata[STAT_OE_BIT] = s_r.tdo_oe;
                        s_nxt.rdata[STAT_DRV_BIT] = q_drive_en;
                    end
                    OFF_IDCODE: s_nxt.rdata = ID_CODE;
                    default: s_nxt.rdata = RDATA_RST;
                endcase
            end
        end
        if (avs_write && s_r.ack && byte_addr == OFF_CTRL
                && avs_byteenable[0]) begin
            s_nxt.soft_rst = avs_writedata[CTRL_RST_BIT];
        end

        // rising edge: take inputs, advance the controller
        if (tck_rise) begin
            s_nxt.state = tap_next(s_r.state, s_r.tms_s2);
            if (s_r.tms_s2) begin
                if (s_r.tms_cnt != 3'(RST_CNT)) begin
                    s_nxt.tms_cnt = s_r.tms_cnt + 3'h1;
                end
            end else begin
                s_nxt.tms_cnt = 3'h0;
            end
            case (s_r.state)
                ST_CAP_IR: s_nxt.ir_sh = IR_CAPTURE;
                ST_SHIFT_IR: begin
                    s_nxt.ir_sh = {s_r.tdi_s2,
                        s_r.ir_sh[IR_W-1:1]};
                end
                ST_CAP_DR: begin
                    case (dr_sel)
                        SEL_BSR: s_nxt.bsr_sh = s_r.ring_s2;
                        SEL_ID: s_nxt.id_sh = ID_CODE;
                        default: s_nxt.byp = 1'b0;
                    endcase
                end
                ST_SHIFT_DR: begin
                    case (dr_sel)
                        SEL_BSR: begin
                            s_nxt.bsr_sh = {s_r.tdi_s2,
                                s_r.bsr_sh[BSR_W-1:1]};
                        end
                        SEL_ID: begin
                            s_nxt.id_sh = {s_r.tdi_s2,
                                s_r.id_sh[ID_W-1:1]};
                        end
                        default: s_nxt.byp = s_r.tdi_s2;
                    endcase
                end
                default: ;
            endcase
        end

        // falling edge: outputs and update latches change here, or in test reset below
        if (tck_fall) begin
            s_nxt.tdo_oe = (s_r.state == ST_SHIFT_IR)
                || (s_r.state == ST_SHIFT_DR);
            if (s_r.state == ST_SHIFT_IR) begin
                s_nxt.tdo = s_r.ir_sh[0];
            end else if (s_r.state == ST_SHIFT_DR) begin
                case (dr_sel)
                    SEL_BSR: s_nxt.tdo = s_r.bsr_sh[0];
                    SEL_ID: s_nxt.tdo = s_r.id_sh[0];
                    default: s_nxt.tdo = s_r.byp;
                endcase
            end
            if (s_r.state == ST_UPD_IR) begin
                s_nxt.ir = s_r.ir_sh; // ends sample-z float too
            end
            if (s_r.state == ST_UPD_DR && dr_sel == SEL_BSR) begin
                s_nxt.bsr_up = s_r.bsr_sh; // preload latch
            end
        end

        // test reset touches only test logic, never the memory path
        if (s_r.state == ST_RESET) begin
            s_nxt.ir = IR_IDCODE;
            s_nxt.bsr_up[TRI_CELL] = 1'b1;
            s_nxt.tdo_oe = 1'b0;
        end
        if (s_r.soft_rst) begin
            s_nxt.state = ST_RESET;
        end

        // power-up reset; mode-select and data-in synchronisers idle high
        if (!reset_n) begin
            s_nxt = '0;
            s_nxt.tms_s1 = PIN_PULL;
            s_nxt.tms_s2 = PIN_PULL;
            s_nxt.tdi_s1 = PIN_PULL;
            s_nxt.tdi_s2 = PIN_PULL;
            s_nxt.state = ST_RESET;
            s_nxt.ir = IR_IDCODE;
            s_nxt.bsr_up[TRI_CELL] = 1'b1;
            s_nxt.tdo_oe = 1'b0;
        end
    end

    // single state register
    always_ff @(posedge clk) begin
        s_r <= s_nxt;
    end

    // outputs; drivers float only under sample-z or extest with cell low
    assign tdo = s_r.tdo;
    assign tdo_oe = s_r.tdo_oe;
    assign bsr_drive = s_r.bsr_up;
    assign extest_active = (s_r.ir == IR_EXTEST);
    always_comb begin
        case (s_r.ir)
            IR_EXTEST: q_drive_en = s_r.bsr_up[TRI_CELL];
            IR_SAMPLEZ: q_drive_en = 1'b0;
            default: q_drive_en = 1'b1;
        endcase
    end
    assign avs_readdata = s_r.rdata;
    assign avs_waitrequest = (avs_read || avs_write) && !s_r.ack;

    // checks on the controller and scan path
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_five_tms_reset: assert property (
        (s_r.tms_cnt == 3'(RST_CNT)) |-> (s_r.state == ST_RESET))
        else $error("five high mode-select rises did not reach reset");

    a_tdo_on_fall: assert property (
        !$stable(s_r.tdo) |-> $past(tck_fall))
        else $error("data out changed away from a falling test clock");

    a_tdo_oe_shift: assert property (
        $rose(s_r.tdo_oe) |-> ($past(s_r.state) == ST_SHIFT_IR
            || $past(s_r.state) == ST_SHIFT_DR))
        else $error("data out enabled outside a shift state");

    a_capture_ir_bits: assert property (
        (tck_rise && s_r.state == ST_CAP_IR)
            |=> (s_r.ir_sh[1:0] == 2'b01) && (s_r.state != ST_CAP_IR))
        else $error("capture-instruction did not load 01");

    a_reset_idcode: assert property (
        (s_r.state == ST_RESET) |=> (s_r.ir == IR_IDCODE))
        else $error("reset state did not load identification code");

    a_bypass_clear: assert property (
        (tck_rise && s_r.state == ST_CAP_DR && s_r.ir == IR_BYPASS)
            |=> !s_r.byp)
        else $error("bypass register not cleared on capture");

    a_shift_msb_in: assert property (
        (tck_rise && s_r.state == ST_SHIFT_DR && dr_sel == SEL_BSR)
            |=> (s_r.bsr_sh[BSR_W-1] == $past(s_r.tdi_s2)))
        else $error("boundary shift did not enter at the msb");

    a_samplez_float: assert property (
        (s_r.ir == IR_SAMPLEZ) |-> !q_drive_en)
        else $error("output bus driven under sample-z");

    a_cell_preset: assert property (
        (s_r.state == ST_RESET) |=> s_r.bsr_up[TRI_CELL])
        else $error("output gate cell not preset high in reset");

    a_state_hold: assert property (
        (!tck_rise && !s_r.soft_rst) |=> $stable(s_r.state))
        else $error("controller moved without a rising test clock");

    // instruction may only move at update or while held in reset
    a_ir_update_only: assert property (
        $changed(s_r.ir) |-> ($past(s_r.state) == ST_RESET
            || ($past(tck_fall) && $past(s_r.state) == ST_UPD_IR)))
        else $error("instruction changed outside update or reset");

    a_oe_off_reset: assert property (
        (s_r.state == ST_RESET) |=> !s_r.tdo_oe)
        else $error("data out enabled after test reset");

    a_ir_msb_in: assert property (
        (tck_rise && s_r.state == ST_SHIFT_IR)
            |=> (s_r.ir_sh[IR_W-1] == $past(s_r.tdi_s2)))
        else $error("instruction shift did not enter at the msb");

    a_tdo_lsb_out: assert property (
        (tck_fall && s_r.state == ST_SHIFT_DR && dr_sel == SEL_BSR)
            |=> (s_r.tdo == $past(s_r.bsr_sh[0])))
        else $error("data out did not take the boundary lsb");

    a_preload_update: assert property (
        (tck_fall && s_r.state == ST_UPD_DR && dr_sel == SEL_BSR)
            |=> (s_r.bsr_up == $past(s_r.bsr_sh)))
        else $error("update did not latch the boundary shift stage");

    a_id_capture: assert property (
        (tck_rise && s_r.state == ST_CAP_DR && dr_sel == SEL_ID)
            |=> (s_r.id_sh == ID_CODE))
        else $error("identification code not captured");

endmodule : bst_tap

// ---- bst_host.sv ----
`timescale 1ns/1ps
// far-side test controller, link clock parked low between frames
module bst_host (
    input wire logic clk,
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe
);
    int oe_bad = 0;
    bit shifting = 0;

    // idle link: clock low, pulled-up lines high
    initial begin
        tck = 1'b0; // parked
        tms = 1'b1;
        tdi = 1'b1;
    end

    // one 124 ns test clock; data out taken at the rise
    task automatic step(input logic m, input logic d, output logic q);
        tms <= m;
        tdi <= d;
        repeat (15) @(posedge clk);
        tck <= 1'b1;
        q = tdo; // taken at rise
        if (shifting && tdo_oe !== 1'b1)
            oe_bad++;
        repeat (16) @(posedge clk);
        tck <= 1'b0;
    endtask : step

    // five high mode-select rises, then optionally idle
    task automatic tap_reset(input bit to_idle);
        logic q;
        repeat (5) step(1'b1, 1'b1, q); // five rises
        if (to_idle)
            step(1'b0, 1'b1, q);
        @(posedge clk);
        tms <= 1'b1;
    endtask : tap_reset

    // idle to idle scan, lsb first out, din lsb sent first
    task automatic scan(input bit ir, input int n,
                        input logic [108:0] din, output logic [108:0] dout);
        logic q;
        dout = '0;
        step(1'b1, 1'b1, q);
        if (ir)
            step(1'b1, 1'b1, q);
        step(1'b0, 1'b1, q);
        step(1'b0, 1'b1, q);
        shifting = 1;
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        shifting = 0;
        step(1'b1, 1'b1, q);
        step(1'b0, 1'b1, q);
        @(posedge clk);
        tms <= 1'b1;
    endtask : scan
endmodule : bst_host

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench;
    import bst_pkg::*;
    localparam logic [31:0] ID_VAL = 32'h0C3A_5E01; // value is arbitrary
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic tck, tms, tdi, tdo, tdo_oe, extest_active, q_drive_en;
    logic [BSR_W-1:0] pin_ring = '0;
    logic [BSR_W-1:0] bsr_drive;
    logic [1:0] avs_address = 2'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [2:0] codes[3] = '{IR_PRELOAD, IR_EXTEST, IR_SAMPLEZ};
    logic [2:0] byp[4] = '{IR_BYPASS, 3'h3, 3'h5, 3'h6};
    logic [108:0] exp_q[$];
    logic [108:0] obs_v;
    event obs_ev;
    int err_count = 0;
    int comparisons = 0;
    int seed = 37251;

    always #2 clk = ~clk;

    bst_tap #(.ID_CODE(ID_VAL)) bst_tap_i (
        .clk(clk), .reset_n(reset_n), .tck(tck), .tms(tms), .tdi(tdi),
        .tdo(tdo), .tdo_oe(tdo_oe), .pin_ring(pin_ring),
        .bsr_drive(bsr_drive), .extest_active(extest_active),
        .q_drive_en(q_drive_en), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest)
    );
    bst_host bst_host_i (
        .clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdo_oe(tdo_oe)
    );

    // scoreboard: oldest note against each observed result
    always @(obs_ev) begin
        logic [108:0] e;
        e = exp_q.pop_front();
        comparisons++;
        if (e !== obs_v) begin
            err_count++;
            $display("Error at %0t: got %h, expected %h", $time, obs_v, e);
        end
    end

    // note an expectation, then publish the observed value
    task automatic chk(input logic [108:0] e, input logic [108:0] v);
        exp_q.push_back(e);
        obs_v = v;
        ->obs_ev;
        @(posedge clk);
    endtask : chk

    // avalon transfer, held until waitrequest seen low
    task automatic bus(input bit wr, input logic [1:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        // no cycle count assumed: only the watchdog ends a stuck wait
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask : bus

    function automatic logic [108:0] rnd();
        logic [127:0] r;
        r = {$random(seed), $random(seed), $random(seed), $random(seed)};
        return r[108:0];
    endfunction : rnd

    task automatic tally_and_finish();
        $display("comparisons %0d, err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish

    // hang guard, well past the expected run length
    initial begin
        repeat (60000) @(posedge clk);
        err_count++;
        $display("Error at %0t: watchdog expired", $time);
        tally_and_finish();
    end

    // main sequence
    initial begin
        logic [108:0] o, d, p;
        logic [31:0] r;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        chk({1'b1, 108'h0}, bsr_drive); // cell preset
        chk(0, tdo_oe); // output floats
        bus(0, 2'h1, 0, r);
        chk(32'h0000_0110, r); // status after power-up
        bus(0, 2'h2, 0, r);
        chk(ID_VAL, r); // id word
        bus(0, 2'h3, 0, r);
        chk(0, r); // unmapped reads zero
        bst_host_i.tap_reset(1);
        bst_host_i.scan(0, ID_W, rnd(), o);
        chk(ID_VAL, o[31:0]); // serial id
        // boundary instructions: capture, shift, update
        foreach (codes[k]) begin
            bst_host_i.scan(1, IR_W, 109'(codes[k]), o);
            chk(IR_CAPTURE, o[2:0]); // capture pattern
            chk(k == 0, q_drive_en); // gate cell
            chk(codes[k] == IR_EXTEST, extest_active); // decode
            d = rnd();
            d[TRI_CELL] = (k != 0);
            p = rnd();
            pin_ring <= p;
            bst_host_i.scan(0, BSR_W, d, o);
            chk(p, o); // ring captured
            if (k < 2)
                chk(d, bsr_drive); // msb-in order
            chk(k != 2, q_drive_en); // output bus float
        end
        // bypass and the reserved codes: one-bit delay, zero first
        foreach (byp[k]) begin
            bst_host_i.scan(1, IR_W, 109'(byp[k]), o);
            d = rnd();
            bst_host_i.scan(0, 8, d, o);
            chk({d[6:0], 1'b0}, o[7:0]); // single bit path
        end
        chk(0, bst_host_i.oe_bad); // enabled while shifting
        chk(0, tdo_oe); // off in idle
        bst_host_i.tap_reset(0);
        bus(0, 2'h1, 0, r);
        chk(32'h0000_0110, r); // reset state, id loaded
        // control-word reset from idle with bypass loaded
        bst_host_i.tap_reset(1);
        bst_host_i.scan(1, IR_W, 109'(IR_BYPASS), o);
        bus(0, 2'h1, 0, r);
        chk(32'h0000_0171, r); // serial load
        // control write with lane 0 masked must be ignored
        avs_byteenable <= 4'hE;
        bus(1, 2'h0, 32'h0000_0001, r);
        avs_byteenable <= 4'hF;
        bus(0, 2'h1, 0, r);
        chk(32'h0000_0171, r); // masked write, bypass still loaded
        bus(1, 2'h0, 32'h0000_0001, r);
        // ir reload trails the entry into reset by one cycle
        repeat (2) @(posedge clk);
        bus(0, 2'h1, 0, r);
        chk(32'h0000_0110, r); // id reloaded
        bus(1, 2'h3, 32'hFFFF_FFFF, r);
        bus(0, 2'h0, 0, r);
        chk(0, r); // control reads zero
        tally_and_finish();
    end
endmodule : testbench
